//--- rtl/ccas_consts.vh
// Constants of the cpu core datapath: opcodes, field widths, I/O map, flags.
// Assumes inclusion by bare name from the core and stack modules.
`ifndef CCAS_CONSTS_VH
`define CCAS_CONSTS_VH

// ****************************************
// Widths
// ****************************************
`define CCAS_PC_W          9
`define CCAS_INSTR_W       16
`define CCAS_DATA_W        8
`define CCAS_IO_ADDR_W     6
`define CCAS_REG_COUNT     32
`define CCAS_PROG_WORDS    512

// ****************************************
// Register and flag positions
// ****************************************
`define CCAS_PTR_LO_IDX    5'h1E
`define CCAS_PTR_HI_IDX    5'h1F
`define CCAS_CONST_DST_IDX 5'h00
`define CCAS_FLAG_IRQ_EN   7
`define CCAS_FLAG_BIT_COPY 6
`define CCAS_FLAGS_OFFSET  6'h3F
`define CCAS_FLAGS_RESET   8'h00
`define CCAS_PC_RESET      9'h000
`define CCAS_BIT_IO_LIMIT  6'h1F
// One bit per I/O location that has a register behind it
`define CCAS_IO_MAP_MASK   64'h8F3FF002_71C001F0

// ****************************************
// Opcodes
// ****************************************
`define CCAS_OP6_ADD       6'h03
`define CCAS_OP6_SUB       6'h06
`define CCAS_OP6_AND       6'h08
`define CCAS_OP6_EOR       6'h09
`define CCAS_OP6_OR        6'h0A
`define CCAS_OP6_MOV       6'h0B
`define CCAS_OP4_LDI       4'hE
`define CCAS_OP4_RJMP      4'hC
`define CCAS_OP4_REL_CALL  4'hD
`define CCAS_OP5_IN        5'h16
`define CCAS_OP5_OUT       5'h17
`define CCAS_OP8_CLR_BIT   8'h98
`define CCAS_OP8_SKIP_ZERO 8'h99
`define CCAS_OP8_SET_BIT   8'h9A
`define CCAS_OP8_SKIP_ONE  8'h9B
`define CCAS_OP7_LD_PTR    7'h40
`define CCAS_OP7_ST_PTR    7'h41
`define CCAS_OP7_BIT_LOAD  7'h7C
`define CCAS_OP7_BIT_STORE 7'h7D
`define CCAS_OP_SUB_RET    16'h9508
`define CCAS_OP_IRQ_RET    16'h9518
`define CCAS_OP_CONST_GET  16'h95C8

`endif

//--- rtl/ccas_core.v
// Cpu core datapath: two-stage fetch/execute, register file, I/O access, flags.
// Assumes a program store answering o_prog_addr in the same cycle and
// I/O peripherals answering o_io_addr combinationally on i_io_rdata.
//
// Function
// - Register ALU op with write-back in one cycle
// - 512 sixteen-bit program words, nine-bit counter
// - Indirect access picks register at pointer low byte
// - Two-register ops write result to destination
// - I/O address from six-bit instruction field
// - Relative jump/call lands at pc plus offset plus one
// - Constant fetch: word from pointer, LSB picks byte
// - Three-level nine-bit dedicated return stack
// - Push to level 0, older levels shift deeper
// - Return takes level 0, deeper levels move up
// - Overflow drops oldest; bottom level repeats on pop
// - Core clocked directly, no clock division
// - Fetch next instruction while executing current one
// - Dedicated I/O read/write instructions to I/O space
// - Bit set/clear/skip for I/O 0x00 to 0x1F
// - No interrupt while enable flag bit 7 clear
// - Interrupt clears enable; interrupt return sets it
// - Bit store/load via flag bit 6
// - Pointer is registers 30/31; high byte used only by constant fetch
`timescale 1ns/100ps
`default_nettype none
`include "ccas_consts.vh"

module ccas_core
(
  // Clock and reset
  input  wire                         i_ref_clk,
  input  wire                         i_rst_b,
  // Program store
  output wire [`CCAS_PC_W-1:0]        o_prog_addr,
  input  wire [`CCAS_INSTR_W-1:0]     i_prog_data,
  // I/O space
  output wire [`CCAS_IO_ADDR_W-1:0]   o_io_addr,
  output wire [`CCAS_DATA_W-1:0]      o_io_wdata,
  output wire                         o_io_we,
  output wire                         o_io_re,
  input  wire [`CCAS_DATA_W-1:0]      i_io_rdata,
  // Interrupt request, already gated by the peripheral masks
  input  wire                         i_irq_req,
  input  wire [`CCAS_PC_W-1:0]        i_irq_vector,
  output wire                         o_irq_ack,
  // Status
  output wire [`CCAS_DATA_W-1:0]      o_status_flags
);

  // ****************************************
  // Helpers
  // ****************************************
  function [`CCAS_PC_W-1:0] rel_target;
    input [`CCAS_PC_W-1:0] base;
    input [11:0]           offs;
    begin
      // Offset wraps modulo the 512-word space
      rel_target = base + offs[`CCAS_PC_W-1:0] + 9'h001;
    end
  endfunction

  function [`CCAS_DATA_W-1:0] put_bit;
    input [`CCAS_DATA_W-1:0] val;
    input [2:0]              pos;
    input                    bit_val;
    reg   [`CCAS_DATA_W-1:0] sel;
    begin
      sel     = 8'h01 << pos;
      put_bit = bit_val ? (val | sel) : (val & ~sel);
    end
  endfunction

  function io_mapped;
    input [`CCAS_IO_ADDR_W-1:0] addr;
    reg   [63:0]                map;
    begin
      map       = `CCAS_IO_MAP_MASK;
      io_mapped = map[addr];
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [`CCAS_PC_W-1:0]    pc;
  reg [`CCAS_PC_W-1:0]    ir_pc;
  reg [`CCAS_INSTR_W-1:0] ir;
  reg                     ir_valid;
  reg [`CCAS_DATA_W-1:0]  flags;
  reg [`CCAS_DATA_W-1:0]  work_reg [0:`CCAS_REG_COUNT-1];

  reg [`CCAS_PC_W-1:0]    next_pc;
  reg                     next_ir_valid;
  reg [`CCAS_DATA_W-1:0]  next_flags;
  reg                     wb_en;
  reg [4:0]               wb_idx;
  reg [`CCAS_DATA_W-1:0]  wb_data;
  reg                     io_we;
  reg                     io_re;
  reg [`CCAS_DATA_W-1:0]  io_wdata;
  reg                     push;
  reg                     pop;
  reg [`CCAS_PC_W-1:0]    push_addr;
  reg [`CCAS_PC_W-1:0]    prog_addr;
  reg                     irq_ack;

  wire [`CCAS_PC_W-1:0]   stack_top;

  // ****************************************
  // Operand fields
  // ****************************************
  wire [4:0]              dst_idx  = ir[8:4];
  wire [4:0]              src_idx  = {ir[9], ir[3:0]};
  wire [4:0]              imm_idx  = {1'b1, ir[7:4]};
  wire [7:0]              imm_val  = {ir[11:8], ir[3:0]};
  wire [2:0]              bit_pos  = ir[2:0];
  wire [7:0]              dst_val  = work_reg[dst_idx];
  wire [7:0]              src_val  = work_reg[src_idx];
  wire [7:0]              ptr_lo   = work_reg[`CCAS_PTR_LO_IDX];
  wire [7:0]              ptr_hi   = work_reg[`CCAS_PTR_HI_IDX];
  // High pointer byte only matters for the constant fetch
  wire                    ptr_in_rf = (ptr_lo < 8'h20);
  wire [7:0]              ptr_val   = work_reg[ptr_lo[4:0]];

  wire                    is_bit_io = (ir[15:10] == 6'h26);
  wire [`CCAS_IO_ADDR_W-1:0] io_addr = is_bit_io ? {1'b0, ir[7:3]}
                                                 : {ir[10:9], ir[3:0]};
  wire                    io_is_flags = (io_addr == `CCAS_FLAGS_OFFSET);
  wire                    io_live     = io_mapped(io_addr) && !io_is_flags;
  wire [7:0]              io_rd_val   = io_is_flags ? flags
                                      : (io_live ? i_io_rdata : 8'h00);
  wire                    io_bit      = io_rd_val[bit_pos];
  wire [15:0]             ptr_word    = {ptr_hi, ptr_lo};

  // ****************************************
  // Execute
  // ****************************************
  always @*
  begin
    next_pc       = pc + 9'h001;
    next_ir_valid = 1'b1;
    next_flags    = flags;
    wb_en         = 1'b0;
    wb_idx        = dst_idx;
    wb_data       = 8'h00;
    io_we         = 1'b0;
    io_re         = 1'b0;
    io_wdata      = 8'h00;
    push          = 1'b0;
    pop           = 1'b0;
    push_addr     = ir_pc + 9'h001;
    prog_addr     = pc;
    irq_ack       = 1'b0;
    if (ir_valid)
    begin
      if (i_irq_req && flags[`CCAS_FLAG_IRQ_EN])
      begin
        // Interrupted instruction is re-run after return
        irq_ack       = 1'b1;
        push          = 1'b1;
        push_addr     = ir_pc;
        next_pc       = i_irq_vector;
        next_ir_valid = 1'b0;
        next_flags[`CCAS_FLAG_IRQ_EN] = 1'b0;
      end
      else if (ir[15:12] == `CCAS_OP4_RJMP)
      begin
        next_pc       = rel_target(ir_pc, ir[11:0]);
        next_ir_valid = 1'b0;
      end
      else if (ir[15:12] == `CCAS_OP4_REL_CALL)
      begin
        push          = 1'b1;
        next_pc       = rel_target(ir_pc, ir[11:0]);
        next_ir_valid = 1'b0;
      end
      else if (ir == `CCAS_OP_SUB_RET || ir == `CCAS_OP_IRQ_RET)
      begin
        pop           = 1'b1;
        next_pc       = stack_top;
        next_ir_valid = 1'b0;
        if (ir == `CCAS_OP_IRQ_RET)
          next_flags[`CCAS_FLAG_IRQ_EN] = 1'b1;
      end
      else if (ir == `CCAS_OP_CONST_GET)
      begin
        // Steals the fetch slot; the word at pc is fetched again next cycle
        prog_addr     = ptr_word[`CCAS_PC_W:1];
        next_pc       = pc;
        next_ir_valid = 1'b0;
        wb_en         = 1'b1;
        wb_idx        = `CCAS_CONST_DST_IDX;
        wb_data       = ptr_word[0] ? i_prog_data[15:8] : i_prog_data[7:0];
      end
      else if (ir[15:12] == `CCAS_OP4_LDI)
      begin
        wb_en   = 1'b1;
        wb_idx  = imm_idx;
        wb_data = imm_val;
      end
      else if (ir[15:11] == `CCAS_OP5_IN)
      begin
        io_re   = io_live;
        wb_en   = 1'b1;
        wb_data = io_rd_val;
      end
      else if (ir[15:11] == `CCAS_OP5_OUT)
      begin
        io_we    = io_live;
        io_wdata = dst_val;
        if (io_is_flags)
          next_flags = dst_val;
      end
      else if (ir[15:8] == `CCAS_OP8_SET_BIT || ir[15:8] == `CCAS_OP8_CLR_BIT)
      begin
        // Read-modify-write in one cycle
        io_re    = io_live;
        io_we    = io_live;
        io_wdata = put_bit(io_rd_val, bit_pos, ir[9]);
      end
      else if (ir[15:8] == `CCAS_OP8_SKIP_ONE || ir[15:8] == `CCAS_OP8_SKIP_ZERO)
      begin
        io_re         = io_live;
        next_ir_valid = (io_bit != ir[9]);
      end
      else if (ir[15:9] == `CCAS_OP7_LD_PTR && ir[3:0] == 4'h0)
      begin
        wb_en   = 1'b1;
        wb_data = ptr_in_rf ? ptr_val : 8'h00;
      end
      else if (ir[15:9] == `CCAS_OP7_ST_PTR && ir[3:0] == 4'h0)
      begin
        wb_en   = ptr_in_rf;
        wb_idx  = ptr_lo[4:0];
        wb_data = dst_val;
      end
      else if (ir[15:9] == `CCAS_OP7_BIT_STORE && !ir[3])
      begin
        next_flags[`CCAS_FLAG_BIT_COPY] = dst_val[bit_pos];
      end
      else if (ir[15:9] == `CCAS_OP7_BIT_LOAD && !ir[3])
      begin
        wb_en   = 1'b1;
        wb_data = put_bit(dst_val, bit_pos, flags[`CCAS_FLAG_BIT_COPY]);
      end
      else
      begin
        // Two-register ALU group; anything else is a no-op
        wb_en = 1'b1;
        case (ir[15:10])
          `CCAS_OP6_ADD: wb_data = dst_val + src_val;
          `CCAS_OP6_SUB: wb_data = dst_val - src_val;
          `CCAS_OP6_AND: wb_data = dst_val & src_val;
          `CCAS_OP6_EOR: wb_data = dst_val ^ src_val;
          `CCAS_OP6_OR:  wb_data = dst_val | src_val;
          `CCAS_OP6_MOV: wb_data = src_val;
          default:       wb_en   = 1'b0;
        endcase
      end
    end
  end

  // ****************************************
  // Pipeline registers
  // ****************************************
  // Single clock domain straight from the reference clock
  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pc       <= `CCAS_PC_RESET;
      ir_pc    <= `CCAS_PC_RESET;
      ir       <= 16'h0000;
      ir_valid <= 1'b0;
      flags    <= `CCAS_FLAGS_RESET;
    end
    else
    begin
      pc       <= next_pc;
      ir       <= i_prog_data;
      ir_pc    <= pc;
      ir_valid <= next_ir_valid;
      flags    <= next_flags;
    end
  end

  // Register file survives reset, so it carries no reset term
  always @(posedge i_ref_clk)
  begin
    if (wb_en)
      work_reg[wb_idx] <= wb_data;
  end

  // ****************************************
  // Return stack
  // ****************************************
  ccas_ret_stack u_ret_stack
  (
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_push      (push),
    .i_pop       (pop),
    .i_push_addr (push_addr),
    .o_top       (stack_top)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign o_prog_addr    = prog_addr;
  assign o_io_addr      = io_addr;
  assign o_io_wdata     = io_wdata;
  assign o_io_we        = io_we;
  assign o_io_re        = io_re;
  assign o_irq_ack      = irq_ack;
  assign o_status_flags = flags;

endmodule
`default_nettype wire

//--- rtl/ccas_ret_stack.v
// Three-level return address stack of the cpu core.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ccas_consts.vh"

module ccas_ret_stack
(
  // Clock and reset
  input  wire                     i_ref_clk,
  input  wire                     i_rst_b,
  // Stack control
  input  wire                     i_push,
  input  wire                     i_pop,
  input  wire [`CCAS_PC_W-1:0]    i_push_addr,
  // Top of stack
  output wire [`CCAS_PC_W-1:0]    o_top
);

  reg [`CCAS_PC_W-1:0] level0;
  reg [`CCAS_PC_W-1:0] level1;
  reg [`CCAS_PC_W-1:0] level2;

  // ****************************************
  // Shift register stack
  // ****************************************
  // Oldest entry falls off the bottom; bottom copies itself up on pop
  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      level0 <= `CCAS_PC_RESET;
      level1 <= `CCAS_PC_RESET;
      level2 <= `CCAS_PC_RESET;
    end
    else if (i_push)
    begin
      level0 <= i_push_addr;
      level1 <= level0;
      level2 <= level1;
    end
    else if (i_pop)
    begin
      level0 <= level1;
      level1 <= level2;
      level2 <= level2;
    end
  end

  assign o_top = level0;

endmodule
`default_nettype wire

//--- testbench/ccas_checker.sv
// Port checker for the cpu core datapath.
// Assumes it is bound to ccas_core and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "ccas_consts.vh"
module ccas_checker
(
  // Clock and reset
  input wire logic                       i_ref_clk,
  input wire logic                       i_rst_b,
  // Program store
  input wire logic [`CCAS_PC_W-1:0]      o_prog_addr,
  input wire logic [`CCAS_INSTR_W-1:0]   i_prog_data,
  // I/O space
  input wire logic [`CCAS_IO_ADDR_W-1:0] o_io_addr,
  input wire logic                       o_io_we,
  input wire logic                       o_io_re,
  // Interrupt and status
  input wire logic                       i_irq_req,
  input wire logic [`CCAS_PC_W-1:0]      i_irq_vector,
  input wire logic                       o_irq_ack,
  input wire logic [`CCAS_DATA_W-1:0]    o_status_flags
);
  localparam logic [63:0] IO_MAP = `CCAS_IO_MAP_MASK;
  // ********
  // Properties
  // ********
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  we_mapped_a: assert property (o_io_we |-> IO_MAP[o_io_addr] && o_io_addr != 6'h3F)
    else $error("write strobe on unmapped or flag address");
  re_mapped_a: assert property (o_io_re |-> IO_MAP[o_io_addr] && o_io_addr != 6'h3F)
    else $error("read strobe on unmapped or flag address");
  bit_range_a: assert property (o_io_we && o_io_re |-> o_io_addr <= `CCAS_BIT_IO_LIMIT)
    else $error("bit access above the bit-addressable range");
  ack_gate_a: assert property (o_irq_ack |-> i_irq_req && o_status_flags[7])
    else $error("interrupt taken while disabled or not requested");
  ack_clear_a: assert property (o_irq_ack |=> !o_status_flags[7] && !o_irq_ack)
    else $error("enable flag not cleared or ack not a single pulse");
  ack_vector_a: assert property (o_irq_ack |=> o_prog_addr == $past(i_irq_vector))
    else $error("fetch after interrupt not from the vector");
  flags_reset_a: assert property ($rose(i_rst_b) |-> o_status_flags == `CCAS_FLAGS_RESET)
    else $error("flags not at reset value after reset");
  irq_set_a: assert property ($rose(o_status_flags[7]) |->
    $past(i_prog_data, 2) == `CCAS_OP_IRQ_RET || $past(o_io_addr) == 6'h3F)
    else $error("enable flag set without return or flag write");
endmodule
`default_nettype wire

//--- testbench/ccas_prog_io.sv
// Program store and I/O register image facing the core.
// Assumes the bench loads mem and io while the core is held in reset.
`timescale 1ns/100ps
`default_nettype none
module ccas_prog_io
(
  // Clock
  input  wire logic        i_ref_clk,
  // Program store
  input  wire logic [8:0]  i_prog_addr,
  output logic      [15:0] o_prog_data,
  // I/O space
  input  wire logic [5:0]  i_io_addr,
  input  wire logic [7:0]  i_io_wdata,
  input  wire logic        i_io_we,
  input  wire logic        i_io_re,
  output logic      [7:0]  o_io_rdata
);
  logic [15:0] mem [0:511];
  logic [7:0]  io [0:63];
  logic [7:0]  junk = 8'hA5;
  assign o_prog_data = mem[i_prog_addr];
  // Unstrobed read bus wanders, so the core cannot lean on stale data
  assign o_io_rdata = i_io_re ? io[i_io_addr] : junk;
  always @(posedge i_ref_clk)
  begin
    junk <= junk + 8'h3B;
    if (i_io_we)
      io[i_io_addr] <= i_io_wdata;
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Bench: small programs run on the core, results read from the I/O image.
// Assumes every program ends writing I/O 0x21 and then spins on itself.
`timescale 1ns/100ps
`default_nettype none
`include "ccas_consts.vh"
module testbench;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_irq_req = 1'b0;
  logic [8:0]  i_irq_vector = 9'h040;
  logic [8:0]  o_prog_addr;
  logic [15:0] i_prog_data;
  logic [5:0]  o_io_addr;
  logic [7:0]  o_io_wdata;
  logic [7:0]  i_io_rdata;
  logic [7:0]  o_status_flags;
  logic        o_io_we;
  logic        o_io_re;
  logic        o_irq_ack;
  int          mismatches = 0;
  int          n_tests = 0;
  int          n_ack = 0;
  int          pa = 0;
  logic [5:0]  ops [6] = '{`CCAS_OP6_ADD, `CCAS_OP6_SUB, `CCAS_OP6_AND, `CCAS_OP6_EOR, `CCAS_OP6_OR, `CCAS_OP6_MOV};
  logic [5:0]  adr [6] = '{6'h18, 6'h17, 6'h2F, 6'h2E, 6'h2D, 6'h2C};
  logic [7:0]  exv [6] = '{8'h41, 8'h29, 8'h04, 8'h39, 8'h3D, 8'h0C};
  ccas_core dut
  (
    .i_ref_clk, .i_rst_b, .o_prog_addr, .i_prog_data, .o_io_addr, .o_io_wdata, .o_io_we,
    .o_io_re, .i_io_rdata, .i_irq_req, .i_irq_vector, .o_irq_ack, .o_status_flags
  );
  ccas_prog_io prt
  (
    .i_ref_clk, .i_prog_addr(o_prog_addr), .o_prog_data(i_prog_data), .i_io_addr(o_io_addr),
    .i_io_wdata(o_io_wdata), .i_io_we(o_io_we), .i_io_re(o_io_re), .o_io_rdata(i_io_rdata)
  );
  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
    if (o_irq_ack === 1'b1)
      n_ack <= n_ack + 1;
  // Request is a level: withdraw once taken, or the return re-enters
  always @(negedge i_ref_clk)
    if (n_ack != 0)
      i_irq_req <= 1'b0;
  // ********
  // Program building
  // ********
  task automatic put(input logic [15:0] w);
    prt.mem[pa] = w;
    pa = pa + 1;
  endtask
  task automatic ldi(input int d, input logic [7:0] k);
    put({`CCAS_OP4_LDI, k[7:4], d[3:0], k[3:0]});
  endtask
  task automatic io(input logic [4:0] op, input logic [5:0] a, input int d);
    put({op, a[5:4], d[4:0], a[3:0]});
  endtask
  task automatic bit8(input logic [7:0] op, input logic [4:0] a, input logic [2:0] b);
    put({op, a, b});
  endtask
  task automatic rel(input logic [3:0] op, input int to);
    put({op, 12'(to - pa - 1)});
  endtask
  task automatic r7(input logic [6:0] op, input int d, input logic [3:0] b);
    put({op, d[4:0], b});
  endtask
  task automatic fin;
    io(`CCAS_OP5_OUT, 6'h21, 0);
    rel(`CCAS_OP4_RJMP, pa);
  endtask
  // ********
  // Run control and checks
  // ********
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic start;
    @(negedge i_ref_clk);
    i_rst_b = 1'b0;
    for (int j = 0; j < 512; j++)
      prt.mem[j] = 16'h0000;
    for (int j = 0; j < 64; j++)
      prt.io[j] = 8'h00;
    pa = 0;
  endtask
  task automatic run(input string nm);
    int k;
    repeat (16) @(negedge i_ref_clk);
    check("flags at reset", o_status_flags, 8'h00);
    i_rst_b = 1'b1;
    // Strobes are combinational, so look mid-cycle where they have settled
    for (k = 0; k < 300; k++)
    begin
      @(negedge i_ref_clk);
      if (o_io_we === 1'b1 && o_io_addr === 6'h21)
        break;
    end
    if (k == 300)
    begin
      mismatches++;
      complete_run();
    end
    else
    begin
      repeat (2) @(negedge i_ref_clk);
      $display("test %s done", nm);
    end
  endtask
  initial
  begin
    start();
    for (int i = 0; i < 6; i++)
    begin
      ldi(16, 8'h35);
      ldi(17, 8'h0C);
      put({ops[i], 1'b1, 5'h10, 4'h1});
      io(`CCAS_OP5_OUT, adr[i], 16);
    end
    ldi(19, 8'h77);
    io(`CCAS_OP5_IN, 6'h05, 18);
    io(`CCAS_OP5_IN, 6'h10, 19);
    io(`CCAS_OP5_OUT, 6'h04, 18);
    io(`CCAS_OP5_OUT, 6'h07, 19);
    io(`CCAS_OP5_OUT, 6'h1D, 18);
    io(`CCAS_OP5_IN, 6'h1D, 20);
    io(`CCAS_OP5_OUT, 6'h1E, 20);
    fin();
    prt.io[5] = 8'h9C;
    run("alu");
    for (int i = 0; i < 6; i++)
      check("alu result", prt.io[adr[i]], exv[i]);
    check("io read", prt.io[4], 8'h9C);
    check("unmapped read", prt.io[7], 8'h00);
    check("data store window", prt.io[6'h1E], 8'h9C);
    start();
    ldi(16, 8'h0F);
    io(`CCAS_OP5_OUT, 6'h18, 16);
    ldi(20, 8'h11);
    ldi(21, 8'h00);
    bit8(`CCAS_OP8_SET_BIT, 5'h18, 3'h7);
    bit8(`CCAS_OP8_CLR_BIT, 5'h18, 3'h0);
    bit8(`CCAS_OP8_SKIP_ONE, 5'h18, 3'h7);
    ldi(20, 8'hEE);
    bit8(`CCAS_OP8_SKIP_ZERO, 5'h18, 3'h0);
    ldi(20, 8'hDD);
    bit8(`CCAS_OP8_SKIP_ZERO, 5'h18, 3'h1);
    ldi(21, 8'h22);
    io(`CCAS_OP5_OUT, 6'h17, 20);
    io(`CCAS_OP5_OUT, 6'h16, 21);
    fin();
    run("bits");
    check("bit set clear", prt.io[6'h18], 8'h8E);
    check("taken skips", prt.io[6'h17], 8'h11);
    check("untaken skip", prt.io[6'h16], 8'h22);
    start();
    ldi(17, 8'h6B);
    ldi(30, 8'h11);
    ldi(31, 8'hFF);
    r7(`CCAS_OP7_LD_PTR, 18, 4'h0);
    io(`CCAS_OP5_OUT, 6'h2F, 18);
    ldi(30, 8'h18);
    ldi(23, 8'h5A);
    r7(`CCAS_OP7_ST_PTR, 23, 4'h0);
    io(`CCAS_OP5_OUT, 6'h30, 24);
    ldi(30, 8'h01);
    ldi(31, 8'h02);
    put(`CCAS_OP_CONST_GET);
    io(`CCAS_OP5_OUT, 6'h2E, 0);
    ldi(30, 8'h00);
    ldi(31, 8'hFE);
    put(`CCAS_OP_CONST_GET);
    io(`CCAS_OP5_OUT, 6'h2D, 0);
    ldi(19, 8'h40);
    r7(`CCAS_OP7_BIT_STORE, 19, 4'h6);
    ldi(20, 8'h00);
    r7(`CCAS_OP7_BIT_LOAD, 20, 4'h2);
    io(`CCAS_OP5_OUT, 6'h2C, 20);
    io(`CCAS_OP5_IN, 6'h3F, 22);
    io(`CCAS_OP5_OUT, 6'h38, 22);
    fin();
    prt.mem[9'h100] = 16'hBEEF;
    run("pointer");
    check("indirect load", prt.io[6'h2F], 8'h6B);
    check("indirect store", prt.io[6'h30], 8'h5A);
    check("const high", prt.io[6'h2E], 8'hBE);
    check("const low", prt.io[6'h2D], 8'hEF);
    check("bit load", prt.io[6'h2C], 8'h04);
    check("flag read", prt.io[6'h38], 8'h40);
    check("flags", o_status_flags, 8'h40);
    start();
    ldi(16, 8'h00);
    io(`CCAS_OP5_OUT, 6'h18, 16);
    io(`CCAS_OP5_OUT, 6'h17, 16);
    rel(`CCAS_OP4_REL_CALL, 6);
    bit8(`CCAS_OP8_SET_BIT, 5'h18, 3'h0);
    rel(`CCAS_OP4_RJMP, 19);
    rel(`CCAS_OP4_REL_CALL, 12);
    bit8(`CCAS_OP8_SKIP_ZERO, 5'h17, 3'h0);
    rel(`CCAS_OP4_RJMP, 19);
    bit8(`CCAS_OP8_SET_BIT, 5'h17, 3'h0);
    bit8(`CCAS_OP8_SET_BIT, 5'h18, 3'h1);
    put(`CCAS_OP_SUB_RET);
    rel(`CCAS_OP4_REL_CALL, 15);
    bit8(`CCAS_OP8_SET_BIT, 5'h18, 3'h2);
    put(`CCAS_OP_SUB_RET);
    rel(`CCAS_OP4_REL_CALL, 18);
    bit8(`CCAS_OP8_SET_BIT, 5'h18, 3'h3);
    put(`CCAS_OP_SUB_RET);
    put(`CCAS_OP_SUB_RET);
    fin();
    run("stack");
    check("return sites", prt.io[6'h18], 8'h0E);
    check("bottom repeat", prt.io[6'h17], 8'h01);
    start();
    i_irq_req = 1'b1;
    ldi(16, 8'h40);
    io(`CCAS_OP5_OUT, 6'h3F, 16);
    ldi(17, 8'h80);
    io(`CCAS_OP5_OUT, 6'h3F, 17);
    io(`CCAS_OP5_OUT, 6'h18, 17);
    fin();
    pa = 9'h040;
    io(`CCAS_OP5_IN, 6'h3F, 18);
    io(`CCAS_OP5_OUT, 6'h2F, 18);
    put(`CCAS_OP_IRQ_RET);
    run("interrupt");
    check("ack count", n_ack[7:0], 8'h01);
    check("flags in handler", prt.io[6'h2F], 8'h00);
    check("rerun after return", prt.io[6'h18], 8'h80);
    check("flags after return", o_status_flags, 8'h80);
    complete_run();
  end
endmodule
bind ccas_core ccas_checker chk
(
  .i_ref_clk, .i_rst_b, .o_prog_addr, .i_prog_data, .o_io_addr, .o_io_we, .o_io_re,
  .i_irq_req, .i_irq_vector, .o_irq_ack, .o_status_flags
);
`default_nettype wire
